// file: rtl/lsd_bus_if.sv
// interface: register write strobe, write/read data and rail enables between the bank and the discharge slice
`timescale 1ns/1ps
interface lsd_bus_if;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] rail_en;
    modport bank (output wr, output wdata, output rail_en, input rdata);
    modport slice (input wr, input wdata, input rail_en, output rdata);
endinterface

// file: rtl/lsd_ctrl.sv
// top: aux linear regulator control and first discharge control registers
// Overview of operation
// RULE1: sleep field 00 uses normal code; 11 uses sleep code while sleep pin low.
// RULE2: host never writes reserved sleep codes 01 or 10.
// RULE3: sleep input choice is a factory strap, not software-visible.
// RULE4: host writes reserved bits 3:1 as 110 on every write.
// RULE5: enable bit 0 turns regulator off regardless of pins; 1 enables it.
// RULE6: discharge code 00 none, 01 100 ohm, 10 200 ohm, 11 500 ohm.
// RULE7: discharge fields for rails one to four at bits 1:0,3:2,5:4,7:6, read/write.
// RULE8: an enabled rail has its discharge field forced to 00.
// RULE9: bits 7:6 of the aux control register read zero, writes ignored.
`timescale 1ns/1ps
module lsd_ctrl
    import lsd_pkg::*;
#(
    parameter bit FACTORY_SLEEP_B = 1'b0
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sleep_input_a,
    input wire logic sleep_input_b,
    input wire logic [3:0] buck_rail_en,
    output logic rail_software_enable,
    output logic use_sleep_voltage_code,
    output logic [3:0] rail_one_discharge_select,
    output logic [3:0] rail_two_discharge_select,
    output logic [3:0] rail_three_discharge_select,
    output logic [3:0] rail_four_discharge_select
);
    lsd_bus_if bus ();

    logic [7:0] aux_ff;
    logic [7:0] nxt_aux;
    logic [1:0] sa_meta_ff;
    logic [1:0] sa_sync_ff;
    logic [3:0] en_meta_ff;
    logic [3:0] en_sync_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic en_out_ff;
    logic slp_out_ff;
    logic [3:0] res_ff [LSD_RAILS];
    logic [3:0] nxt_res [LSD_RAILS];
    logic sleep_pin;

    // decode a two-bit discharge code into a one-hot resistor select
    function automatic lsd_res_type lsd_res_dec(input logic [1:0] code);
        unique case (code)
            2'h0: lsd_res_dec = LSD_R_OFF;
            2'h1: lsd_res_dec = LSD_R_100;
            2'h2: lsd_res_dec = LSD_R_200;
            2'h3: lsd_res_dec = LSD_R_500;
        endcase
    endfunction

    // pins and rail enables come from outside this domain: two flops each
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sa_meta_ff <= 2'h3;
            sa_sync_ff <= 2'h3;
            en_meta_ff <= 4'h0;
            en_sync_ff <= 4'h0;
        end
        else
        begin
            sa_meta_ff <= {sleep_input_b, sleep_input_a};
            sa_sync_ff <= sa_meta_ff;
            en_meta_ff <= buck_rail_en;
            en_sync_ff <= en_meta_ff;
        end
    end

    // strap picks the sleep pin; no register reaches it
    assign sleep_pin = FACTORY_SLEEP_B ? sa_sync_ff[1] : sa_sync_ff[0]; // [RULE3]

    assign bus.wr = reg_wr && (reg_addr == LSD_ADDR_DISCH_ONE);
    assign bus.wdata = reg_wdata;
    assign bus.rail_en = en_sync_ff;

    lsd_disch u_disch (
        .core_clk(core_clk),
        .nrst(nrst),
        .bus(bus)
    );

    // aux control write; top two bits masked away, reserved bits stored as written
    always_comb
    begin
        nxt_aux = aux_ff;
        if (reg_wr && reg_addr == LSD_ADDR_AUX_CTRL)
        begin
            nxt_aux = reg_wdata & LSD_AUX_WMASK; // [RULE9] [RULE4]
        end
    end

    // read mux; unmapped and the second discharge register (not held here) read zero
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (reg_rd)
        begin
            unique case (reg_addr)
                LSD_ADDR_AUX_CTRL: nxt_rdata = aux_ff & LSD_AUX_WMASK; // [RULE9]
                LSD_ADDR_DISCH_ONE: nxt_rdata = bus.rdata;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // per-rail discharge select decode; in the output register below, reserved sleep codes behave as normal code
    always_comb
    begin
        for (int i = 0; i < LSD_RAILS; i++)
        begin
            nxt_res[i] = lsd_res_dec(bus.rdata[i*LSD_FLD_W +: LSD_FLD_W]); // [RULE6]
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aux_ff <= LSD_AUX_RST;
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
            en_out_ff <= 1'b0;
            slp_out_ff <= 1'b0;
            for (int i = 0; i < LSD_RAILS; i++)
            begin
                res_ff[i] <= LSD_R_OFF;
            end
        end
        else
        begin
            aux_ff <= nxt_aux;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= reg_rd;
            en_out_ff <= aux_ff[LSD_EN_BIT]; // [RULE5]
            slp_out_ff <= (aux_ff[LSD_SLP_HI:LSD_SLP_LO] == LSD_SLP_PIN) && !sleep_pin; // [RULE1]
            for (int i = 0; i < LSD_RAILS; i++)
            begin
                res_ff[i] <= nxt_res[i];
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign rail_software_enable = en_out_ff;
    assign use_sleep_voltage_code = slp_out_ff;
    assign rail_one_discharge_select = res_ff[0];
    assign rail_two_discharge_select = res_ff[1];
    assign rail_three_discharge_select = res_ff[2];
    assign rail_four_discharge_select = res_ff[3];

    sequence s_aux_wr_en0;
        reg_wr && reg_addr == LSD_ADDR_AUX_CTRL && !reg_wdata[LSD_EN_BIT];
    endsequence

    property p_disable;
        @(posedge core_clk) disable iff (!nrst)
        s_aux_wr_en0 ##1 !(reg_wr && reg_addr == LSD_ADDR_AUX_CTRL) |=> !rail_software_enable;
    endproperty
    a_disable: assert property (p_disable) else $error("regulator not off after disable"); // [RULE5]

    property p_normal;
        @(posedge core_clk) disable iff (!nrst)
        (aux_ff[LSD_SLP_HI:LSD_SLP_LO] == LSD_SLP_NORMAL) |=> !use_sleep_voltage_code;
    endproperty
    a_normal: assert property (p_normal) else $error("sleep code used in normal mode"); // [RULE1]

    property p_sleep;
        @(posedge core_clk) disable iff (!nrst)
        (aux_ff[LSD_SLP_HI:LSD_SLP_LO] == LSD_SLP_PIN && !sleep_pin) |=> use_sleep_voltage_code;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep code not used with pin low"); // [RULE1]

    property p_top_zero;
        @(posedge core_clk) disable iff (!nrst)
        (reg_rd && reg_addr == LSD_ADDR_AUX_CTRL) |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("aux bits 7:6 not zero"); // [RULE9]

    property p_res_map;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |=> rail_two_discharge_select == lsd_res_dec($past(bus.rdata[3:2]));
    endproperty
    a_res_map: assert property (p_res_map) else $error("discharge decode wrong"); // [RULE6] [RULE7]

    property p_strap;
        @(posedge core_clk) disable iff (!nrst)
        // the chosen pin, two flops late; the other pin must never leak through
        FACTORY_SLEEP_B ? (sleep_pin == $past(sleep_input_b, 2)) : (sleep_pin == $past(sleep_input_a, 2));
    endproperty
    a_strap: assert property (p_strap) else $error("sleep pin not from strap"); // [RULE3]
endmodule

// file: rtl/lsd_disch.sv
// discharge control register with per-rail clear while the rail is enabled
`timescale 1ns/1ps
module lsd_disch
    import lsd_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    lsd_bus_if.slice bus
);
    logic [7:0] disch_ff;
    logic [7:0] nxt_disch;

    // write first, then enabled rails force their field to zero
    always_comb
    begin
        nxt_disch = disch_ff;
        if (bus.wr)
        begin
            nxt_disch = bus.wdata; // [RULE7]
        end
        for (int i = 0; i < LSD_RAILS; i++)
        begin
            if (bus.rail_en[i])
            begin
                nxt_disch[i*LSD_FLD_W +: LSD_FLD_W] = LSD_DIS_NONE; // [RULE8]
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            disch_ff <= LSD_DISCH_RST;
        end
        else
        begin
            disch_ff <= nxt_disch;
        end
    end

    assign bus.rdata = disch_ff;

    property p_rail_clear;
        @(posedge core_clk) disable iff (!nrst)
        bus.rail_en[0] |=> disch_ff[1:0] == 2'h0;
    endproperty
    a_rail_clear: assert property (p_rail_clear) else $error("enabled rail kept discharge"); // [RULE8]

    property p_write_store;
        @(posedge core_clk) disable iff (!nrst)
        (bus.wr && bus.rail_en == 4'h0) |=> disch_ff == $past(bus.wdata);
    endproperty
    a_write_store: assert property (p_write_store) else $error("discharge write lost"); // [RULE7]
endmodule

// file: rtl/lsd_pkg.sv
// package: register map, field layout and reset values for the regulator control slice
package lsd_pkg;
    localparam logic [7:0] LSD_ADDR_AUX_CTRL = 8'h29;
    localparam logic [7:0] LSD_ADDR_DISCH_ONE = 8'h40;
    localparam logic [7:0] LSD_ADDR_DISCH_TWO = 8'h41;
    // aux linear control field positions
    localparam int LSD_SLP_HI = 5;
    localparam int LSD_SLP_LO = 4;
    localparam int LSD_RSV_HI = 3;
    localparam int LSD_RSV_LO = 1;
    localparam int LSD_EN_BIT = 0;
    // writable bits of the aux control register; 7:6 read as zero
    localparam logic [7:0] LSD_AUX_WMASK = 8'h3f;
    // reset values (reset is unspecified, plain defaults chosen)
    localparam logic [7:0] LSD_AUX_RST = 8'h0c;
    localparam logic [7:0] LSD_DISCH_RST = 8'h55;
    localparam int LSD_RAILS = 4;
    localparam int LSD_FLD_W = 2;
    localparam logic [1:0] LSD_SLP_NORMAL = 2'h0;
    localparam logic [1:0] LSD_SLP_PIN = 2'h3;
    localparam logic [1:0] LSD_DIS_NONE = 2'h0;
    // discharge resistance one-hot select
    typedef enum logic [3:0] {
        LSD_R_OFF = 4'h1,
        LSD_R_100 = 4'h2,
        LSD_R_200 = 4'h4,
        LSD_R_500 = 4'h8
    } lsd_res_type;
endpackage

// file: test/lsd_ctrl_bench.sv
// self-checking bench for the aux regulator control and discharge register slice
`timescale 1ns/1ps
module lsd_ctrl_bench;
    import lsd_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic sleep_input_a = 1'b1;
    logic sleep_input_b = 1'b1;
    logic [3:0] buck_rail_en = 4'h0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic rail_software_enable;
    logic use_sleep_voltage_code;
    logic [3:0] r1, r2, r3, r4;
    logic [7:0] aux, dis;
    logic [3:0] en;
    integer seed = 84824;
    integer err_count = 0;
    integer compares = 0;

    // 250 MHz clock
    always #2 core_clk = ~core_clk;

    lsd_ctrl #(.FACTORY_SLEEP_B(1'b0)) dut_u (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sleep_input_a(sleep_input_a), .sleep_input_b(sleep_input_b),
        .buck_rail_en(buck_rail_en), .rail_software_enable(rail_software_enable),
        .use_sleep_voltage_code(use_sleep_voltage_code), .rail_one_discharge_select(r1),
        .rail_two_discharge_select(r2), .rail_three_discharge_select(r3), .rail_four_discharge_select(r4));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-hot resistance select expected on the four rail outputs
    function automatic logic [15:0] dec(input logic [7:0] d);
        logic [15:0] v;
        for (int i = 0; i < 4; i++)
            v[i*4 +: 4] = 4'h1 << d[i*2 +: 2];
        return v;
    endfunction

    // stored discharge value once enabled rails have had their field cleared
    function automatic logic [7:0] clr(input logic [7:0] d, input logic [3:0] e);
        logic [7:0] v;
        v = d;
        for (int i = 0; i < 4; i++)
            if (e[i])
                v[i*2 +: 2] = 2'h0;
        return v;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
    endtask

    // read data and its valid pulse are looked at in the one cycle the valid pulse stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1;
        // rvalid stands only until the next edge, so look before it passes
        chk({reg_rvalid, reg_rdata}, {1'b1, exp});
        reg_rd = 1'b0;
    endtask

    // pins pass a two-flop synchroniser before the output register, so allow margin
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under this span
    initial
    begin
        #40000;
        err_count = err_count + 1;
        tally_and_finish();
    end

    // main sequence: reset values, corner codes, unmapped places, then random traffic
    initial
    begin
        repeat (20) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        rd(LSD_ADDR_AUX_CTRL, LSD_AUX_RST); // aux reset value
        rd(LSD_ADDR_DISCH_ONE, LSD_DISCH_RST); // discharge reset value
        chk({r4, r3, r2, r1}, dec(LSD_DISCH_RST)); // reset decode
        wr(LSD_ADDR_DISCH_ONE, 8'he4);
        rd(LSD_ADDR_DISCH_ONE, 8'he4); // each field in place
        chk({r4, r3, r2, r1}, dec(8'he4)); // all four codes decoded
        wr(LSD_ADDR_DISCH_TWO, 8'hff);
        wr(8'h7f, 8'hff);
        rd(LSD_ADDR_DISCH_TWO, 8'h00);
        rd(8'h7f, 8'h00);
        rd(LSD_ADDR_DISCH_ONE, 8'he4); // unmapped writes left it alone
        for (int n = 0; n < 40; n++)
        begin
            aux = $random(seed);
            aux[3:1] = 3'b110; // host keeps the reserved pattern
            aux[5:4] = {2{aux[5]}}; // only the two legal sleep codes
            sleep_input_a = $random(seed);
            sleep_input_b = $random(seed);
            wr(LSD_ADDR_AUX_CTRL, aux);
            settle();
            chk(rail_software_enable, aux[0]); // software enable copy
            chk(use_sleep_voltage_code, aux[5:4] == 2'h3 && !sleep_input_a); // strap picks input a
            rd(LSD_ADDR_AUX_CTRL, aux & 8'h3f); // top bits read zero
            dis = $random(seed);
            en = $random(seed);
            if (n[0])
                en = 4'h0;
            wr(LSD_ADDR_DISCH_ONE, dis);
            buck_rail_en = en;
            settle();
            rd(LSD_ADDR_DISCH_ONE, clr(dis, en)); // enabled rails cleared
            chk({r4, r3, r2, r1}, dec(clr(dis, en))); // decode after clear
            buck_rail_en = 4'h0;
            settle();
            rd(LSD_ADDR_DISCH_ONE, clr(dis, en)); // cleared field stays after disable
        end
        tally_and_finish();
    end
endmodule
